// File: dv/fault_status_monitor_bench.sv
/*
  Self-checking bench for the fault monitor.
  Assumes the bus master model and the bound checker.
*/
`include "fsm_defs.vh"
module fault_status_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [31:0] SN = 32'h00A5C31E; // Arbitrary
  localparam [4:0] TY = 5'h0B; // Arbitrary
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic gnd = 1'b0, hold_cap_supply = 1'b0, regulator_cap_node = 1'b0, frame = 1'b0, par = 1'b0, fuse = 1'b0;
  logic pin = 1'b0;
  logic [31:0] v, w;
  int fail_count = 0;
  int samples_checked = 0;
  wire hsel, hwrite, hready, hresp, spi, fmi, gf, acc, uv, zero, drst, sw;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  wire [5:0] fl = {zero, uv, acc, gf, drst, sw};
  // Short fault hold keeps the run short
  fsm_monitor #(.GF_CYC(50), .TO_CYC(20), .SERIAL(SN), .TYPE_BITS(TY)) i_dut (.hclk,
    .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp(hresp), .ground_open_cmp(gnd), .hold_cap_low(hold_cap_supply),
    .regulator_cap_low(regulator_cap_node),
    .bus_below_frame(frame), .otp_parity_err(par), .otp_fuse_err(fuse),
    .ground_sense_pin(pin), .spi_din(spi), .filter_monitor_as_input(fmi),
    .ground_fault_flag(gf), .accel_fault_flag(acc), .undervoltage_flag(uv),
    .accel_force_zero(zero), .device_in_reset(drst), .bus_switch_closed(sw));
  fsm_ahb_master i_mst (.hclk, .hready, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  initial
  begin
    forever #50 hclk = ~hclk;
  end
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fchk(logic [5:0] e);
    chk("flags", {26'h0, e}, {26'h0, fl});
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    i_mst.xfer(1'b1, {20'h0, a}, d, w);
  endtask
  task automatic rd(logic [11:0] a);
    i_mst.xfer(1'b0, {20'h0, a}, 32'h0, v);
  endtask
  task automatic rst();
    @(posedge hclk);
    hresetn <= 1'b0;
    {gnd, hold_cap_supply, regulator_cap_node, frame, par, fuse, pin} <= 7'h00;
    cyc(4);
    hresetn <= 1'b1;
    // Flags leave their reset values one edge after release
    cyc(2);
  endtask
  task automatic t_ident();
    fchk(6'h00);
    rd(`FSM_REG_SN);
    chk("serial", SN, v);
    chk("hresp", 32'h0, {31'h0, hresp});
    chk("hready", 32'h1, {31'h0, hready});
    rd(`FSM_REG_TYPE);
    chk("type", {27'h0, TY}, v);
  endtask
  task automatic t_filter();
    logic [31:0] u;
    gnd <= 1'b1;
    cyc(800);
    rd(`FSM_REG_GLCNT);
    chk("cnt_off", 32'h0, v);
    wr(`FSM_REG_CTRL, 32'h00000120);
    cyc(800);
    rd(`FSM_REG_GLCNT);
    chk("cnt_diff", 32'h0, v);
    wr(`FSM_REG_CTRL, 32'h00000020);
    cyc(1000);
    rd(`FSM_REG_GLCNT);
    u = v;
    chk("cnt_up", 32'h1, {31'h0, u > 32'h17C && u < 32'h1A4});
    gnd <= 1'b0;
    cyc(500);
    rd(`FSM_REG_GLCNT);
    chk("cnt_down", 32'h1, {31'h0, v < u && v > 32'h0});
    cyc(1500);
    rd(`FSM_REG_GLCNT);
    chk("cnt_floor", 32'h0, v);
  endtask
  task automatic t_loss();
    wr(`FSM_REG_CTRL, 32'h00000020);
    gnd <= 1'b1;
    cyc(40000);
    fchk(6'h00);
    cyc(1500);
    fchk(6'h2C);
  endtask
  task automatic t_hold_cap_supply();
    hold_cap_supply <= 1'b1;
    cyc(500);
    fchk(6'h30);
    hold_cap_supply <= 1'b0;
    cyc(10);
    hold_cap_supply <= 1'b1;
    cyc(10100);
    fchk(6'h02);
  endtask
  task automatic t_hard();
    regulator_cap_node <= 1'b1;
    cyc(30);
    fchk(6'h02);
    regulator_cap_node <= 1'b0;
    cyc(10);
    fchk(6'h00);
    frame <= 1'b1;
    cyc(40);
    fchk(6'h02);
  endtask
  task automatic t_otp();
    for (int i = 1; i < 3; i++)
    begin
      {fuse, par} <= i[1:0];
      cyc(10);
      fchk(6'h28);
      {fuse, par} <= 2'b00;
      cyc(10);
      fchk(6'h00);
    end
  endtask
  task automatic t_lock();
    wr(`FSM_REG_CMD, 32'h00000002);
    wr(`FSM_REG_CMD, 32'h00000004);
    wr(`FSM_REG_CMD, 32'h00000002);
    rd(`FSM_REG_STAT);
    chk("no_lock", 32'h0, v & 32'h10);
    wr(`FSM_REG_CMD, 32'h00000002);
    rd(`FSM_REG_STAT);
    chk("lock", 32'h10, v & 32'h10);
    par <= 1'b1;
    cyc(10);
    par <= 1'b0;
    cyc(10);
    fchk(6'h28);
    wr(`FSM_REG_CMD, 32'h00000001);
    cyc(5);
    fchk(6'h00);
  endtask
  task automatic t_switch();
    wr(`FSM_REG_CMD, 32'h00000008);
    cyc(2);
    fchk(6'h00);
    wr(`FSM_REG_CMD, 32'h00000048);
    cyc(2);
    fchk(6'h01);
  endtask
  task automatic t_test();
    wr(`FSM_REG_CTRL, 32'h00000600);
    pin <= 1'b1;
    cyc(5);
    chk("test_pins", 32'h3, {30'h0, spi, fmi});
    pin <= 1'b0;
    cyc(5);
    chk("test_pins", 32'h1, {30'h0, spi, fmi});
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #7000000;
    fail_count++;
    complete_run();
  end
  initial
  begin
    rst();
    t_ident();
    t_filter();
    rst();
    t_loss();
    rst();
    t_hold_cap_supply();
    rst();
    t_hard();
    rst();
    t_otp();
    t_lock();
    rst();
    t_switch();
    t_test();
    complete_run();
  end
endmodule

// File: dv/fsm_ahb_master.sv
/*
  Bus master standing in for the controller; single word transfers.
  Assumes one slave whose hreadyout comes back as hready.
*/
module fsm_ahb_master
(
  input logic hclk,
  input logic hready,
  input logic [31:0] hrdata,
  output logic hsel = 1'b0,
  output logic [31:0] haddr = 32'h00000000,
  output logic [1:0] htrans = 2'h0,
  output logic hwrite = 1'b0,
  output logic [2:0] hsize = 3'h2,
  output logic [31:0] hwdata = 32'h00000000
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clear, lockout pair and init travel as plain writes
  task automatic xfer(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do
      @(posedge hclk);
    while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge hclk);
    while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

// File: dv/fsm_monitor_assertions.sv
/*
  Checker for the monitor's flags and hard-reset timing.
  Assumes it is bound to fsm_monitor and sees only its ports.
*/
module fsm_chk
#(
  parameter TO_CYC = 5000
)
(
  input wire hclk,
  input wire hresetn,
  input wire hold_cap_low,
  input wire regulator_cap_low,
  input wire bus_below_frame,
  input wire otp_parity_err,
  input wire otp_fuse_err,
  input wire ground_fault_flag,
  input wire accel_fault_flag,
  input wire undervoltage_flag,
  input wire accel_force_zero,
  input wire device_in_reset,
  input wire bus_switch_closed
);
  reg [15:0] hold_cap_supply_cnt_reg;
  reg [15:0] frame_cnt_reg;
  wire any_flag = ground_fault_flag || accel_fault_flag || undervoltage_flag;
  // Run lengths in counters, far too long to unroll
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hold_cap_supply_cnt_reg <= 16'h0000;
      frame_cnt_reg <= 16'h0000;
    end
    else
    begin
      hold_cap_supply_cnt_reg <= hold_cap_low ? hold_cap_supply_cnt_reg + {15'h0000, ~&hold_cap_supply_cnt_reg} : 16'h0000;
      frame_cnt_reg <= bus_below_frame ? frame_cnt_reg + {15'h0000, ~&frame_cnt_reg} : 16'h0000;
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_otp_held;
    (otp_parity_err || otp_fuse_err) [*4] ##0 !device_in_reset;
  endsequence
  sequence s_hold_cap_supply_dip;
    hold_cap_low [*6];
  endsequence
  AST_OTP_FAULT: assert property (s_otp_held |-> ##[0:2] accel_fault_flag)
    else $error("otp fault without accel flag");
  AST_FORCE_ZERO: assert property (any_flag |-> ##[0:1] accel_force_zero)
    else $error("flag without forced zero");
  AST_GF_ACC: assert property (ground_fault_flag |-> ##[0:1] accel_fault_flag)
    else $error("ground fault without accel flag");
  AST_REG_LOW: assert property (regulator_cap_low [*4] |-> ##[0:2] device_in_reset)
    else $error("regulator low without reset");
  AST_HOLD_CAP_SUPPLY_DIP: assert property (s_hold_cap_supply_dip |-> ##[0:2] (undervoltage_flag || device_in_reset))
    else $error("hold cap dip without flag");
  AST_HOLD_CAP_SUPPLY_LONG: assert property (hold_cap_supply_cnt_reg >= 16'h271A |-> device_in_reset)
    else $error("long hold cap dip without reset");
  AST_FRAME_TO: assert property (frame_cnt_reg >= TO_CYC + 8 |-> device_in_reset)
    else $error("frame timeout without reset");
  AST_SW_OPEN: assert property (device_in_reset |-> ##1 !bus_switch_closed)
    else $error("switch closed in reset");
endmodule

bind fsm_monitor fsm_chk #(.TO_CYC(TO_CYC)) i_chk (.hclk, .hresetn, .hold_cap_low,
  .regulator_cap_low, .bus_below_frame, .otp_parity_err, .otp_fuse_err, .ground_fault_flag,
  .accel_fault_flag, .undervoltage_flag, .accel_force_zero, .device_in_reset,
  .bus_switch_closed);

// File: src/fsm_defs.vh
/*
  Constants for the fault and status monitor: timing counts, field positions,
  reset values and register offsets.
  Assumes a 10 MHz bus clock; the hold-cap and ground-fault counts are derived from it here.
*/
`ifndef FSM_DEFS_VH
`define FSM_DEFS_VH

`define FSM_CLK_HZ 10000000
`define FSM_OSC_HZ 4000000
`define FSM_OSC_ACC_W 24
`define FSM_GL_CNT_W 14
`define FSM_GL_CNT_MAX 14'h3FFF
`define FSM_UV_TIME_US 1000
`define FSM_UV_CYC ((`FSM_UV_TIME_US * (`FSM_CLK_HZ / 1000000)))
`define FSM_UV_CNT_W 16
`define FSM_GF_TIME_NS 4096000
`define FSM_GF_CYC ((`FSM_GF_TIME_NS / 1000) * (`FSM_CLK_HZ / 1000000))
`define FSM_GF_CNT_W 16
`define FSM_TO_CYC 5000

`define FSM_REG_CTRL 12'h000
`define FSM_REG_STAT 12'h004
`define FSM_REG_CMD 12'h008
`define FSM_REG_SN 12'h00C
`define FSM_REG_TYPE 12'h010
`define FSM_REG_GLCNT 12'h014

`define FSM_CFG2_GROUND_LOSS_DETECT_ENABLE_BIT 5
`define FSM_CTRL_CFG2_LSB 0
`define FSM_CTRL_DIFF_BIT 8
`define FSM_CTRL_TEST_BIT 9
`define FSM_CTRL_FILIN_BIT 10
`define FSM_CTRL_RESET 32'h00000000

`define FSM_ST_ACC_BIT 0
`define FSM_ST_GF_BIT 1
`define FSM_ST_UV_BIT 2
`define FSM_ST_RST_BIT 3
`define FSM_ST_LOCK_BIT 4
`define FSM_ST_SW_BIT 5
`define FSM_ST_ZERO_BIT 6

`define FSM_CMD_CLEAR_BIT 0
`define FSM_CMD_SELFTEST_LOCKOUT_BIT 1
`define FSM_CMD_OTHER_BIT 2
`define FSM_CMD_INIT_BIT 3
`define FSM_INIT_D6_BIT 6

`define FSM_TYPE_W 5

`endif

// File: src/fsm_monitor.v
/*
  Fault and status monitor with an AHB-Lite register slave.
  Assumes one AHB-Lite master, single word transfers, and analog comparator
  levels on pins that are asynchronous to hclk.
*/
`include "fsm_defs.vh"
module fsm_monitor
#(
  parameter GF_CYC = `FSM_GF_CYC,
  parameter TO_CYC = `FSM_TO_CYC,
  parameter [31:0] SERIAL = 32'h00000001,
  parameter [4:0] TYPE_BITS = 5'h01
)
(
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire ground_open_cmp,
  input wire hold_cap_low,
  input wire regulator_cap_low,
  input wire bus_below_frame,
  input wire otp_parity_err,
  input wire otp_fuse_err,
  input wire ground_sense_pin,
  output reg spi_din,
  output reg filter_monitor_as_input,
  output reg ground_fault_flag,
  output reg accel_fault_flag,
  output reg undervoltage_flag,
  output reg accel_force_zero,
  output reg device_in_reset,
  output reg bus_switch_closed
);

  wire [6:0] pins_sync;
  reg [31:0] ctrl_reg;
  reg [`FSM_OSC_ACC_W-1:0] osc_acc_reg;
  reg osc_tick_reg;
  reg [`FSM_GL_CNT_W-1:0] gl_cnt_reg;
  reg gl_loss_reg;
  reg [`FSM_GF_CNT_W-1:0] gf_cnt_reg;
  reg gf_hit_reg;
  reg [`FSM_UV_CNT_W-1:0] uv_cnt_reg;
  reg uv_long_reg;
  reg [15:0] to_cnt_reg;
  reg to_hit_reg;
  reg gf_lat_reg;
  reg acc_lat_reg;
  reg uv_lat_reg;
  reg lockout_reg;
  reg last_selftest_lockout_reg;
  reg ph_valid_reg;
  reg ph_write_reg;
  reg [11:0] ph_addr_reg;
  wire gl_cmp = pins_sync[0];
  wire hold_cap_supply_low = pins_sync[1];
  wire regulator_cap_node_low = pins_sync[2];
  wire frame_low = pins_sync[3];
  wire par_err = pins_sync[4];
  wire fuse_err = pins_sync[5];
  // Test data pin is asynchronous too; costs two cycles of delay
  wire sense_pin = pins_sync[6];
  wire test_mode = ctrl_reg[`FSM_CTRL_TEST_BIT];
  wire gl_enable = ctrl_reg[`FSM_CTRL_CFG2_LSB + `FSM_CFG2_GROUND_LOSS_DETECT_ENABLE_BIT]
    & ~ctrl_reg[`FSM_CTRL_DIFF_BIT] & ~test_mode;
  wire hard_reset = regulator_cap_node_low | uv_long_reg | to_hit_reg;
  wire wr_cmd = ph_valid_reg & ph_write_reg & (ph_addr_reg == `FSM_REG_CMD);
  wire cmd_clear = wr_cmd & hwdata[`FSM_CMD_CLEAR_BIT] & ~hard_reset;
  wire cmd_selftest_lockout = wr_cmd & hwdata[`FSM_CMD_SELFTEST_LOCKOUT_BIT] & ~hard_reset;
  wire cmd_other = wr_cmd & (hwdata[`FSM_CMD_OTHER_BIT] | hwdata[`FSM_CMD_CLEAR_BIT]
    | hwdata[`FSM_CMD_INIT_BIT]) & ~hard_reset;
  wire cmd_init = wr_cmd & hwdata[`FSM_CMD_INIT_BIT] & ~hard_reset;
  wire fault_now_acc = gf_hit_reg | par_err | fuse_err;
  wire ph_start = hsel & hready & htrans[1];
  wire [32:0] osc_sum = {9'h000, osc_acc_reg} + 33'h000400000;
  reg [31:0] rd_next;

  fsm_sync2 #(.W(7)) u_sync
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({ground_sense_pin, otp_fuse_err, otp_parity_err, bus_below_frame, regulator_cap_low,
      hold_cap_low, ground_open_cmp}),
    .q(pins_sync)
  );

  // Fractional divider: 4 MHz tick derived from 10 MHz bus clock
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      osc_acc_reg <= {`FSM_OSC_ACC_W{1'b0}};
      osc_tick_reg <= 1'b0;
    end
    else if (osc_sum >= 33'h000A00000)
    begin
      osc_acc_reg <= osc_sum[`FSM_OSC_ACC_W-1:0] - 24'hA00000;
      osc_tick_reg <= 1'b1;
    end
    else
    begin
      osc_acc_reg <= osc_sum[`FSM_OSC_ACC_W-1:0];
      osc_tick_reg <= 1'b0;
    end
  end

  // Up/down filter; reverse instead of clear gives low-pass immunity
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gl_cnt_reg <= {`FSM_GL_CNT_W{1'b0}};
      gl_loss_reg <= 1'b0;
    end
    else if (!gl_enable || hard_reset)
    begin
      gl_cnt_reg <= {`FSM_GL_CNT_W{1'b0}};
      gl_loss_reg <= 1'b0;
    end
    else if (osc_tick_reg)
    begin
      if (gl_cmp)
      begin
        if (gl_cnt_reg == `FSM_GL_CNT_MAX)
          gl_loss_reg <= 1'b1;
        else
          gl_cnt_reg <= gl_cnt_reg + 14'h0001;
      end
      else
      begin
        gl_loss_reg <= 1'b0;
        if (gl_cnt_reg != {`FSM_GL_CNT_W{1'b0}})
          gl_cnt_reg <= gl_cnt_reg - 14'h0001;
      end
    end
  end

  // Ground loss must persist before it becomes a ground fault
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gf_cnt_reg <= {`FSM_GF_CNT_W{1'b0}};
      gf_hit_reg <= 1'b0;
    end
    else if (!gl_loss_reg)
    begin
      gf_cnt_reg <= {`FSM_GF_CNT_W{1'b0}};
      gf_hit_reg <= 1'b0;
    end
    else if (gf_cnt_reg >= GF_CYC[`FSM_GF_CNT_W-1:0])
      gf_hit_reg <= 1'b1;
    else
      gf_cnt_reg <= gf_cnt_reg + 16'h0001;
  end

  // Hold-cap dip: short sets flag, long becomes reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      uv_cnt_reg <= {`FSM_UV_CNT_W{1'b0}};
      uv_long_reg <= 1'b0;
    end
    else if (!hold_cap_supply_low)
    begin
      uv_cnt_reg <= {`FSM_UV_CNT_W{1'b0}};
      uv_long_reg <= 1'b0;
    end
    else if (uv_cnt_reg >= `FSM_UV_CYC)
      uv_long_reg <= 1'b1;
    else
      uv_cnt_reg <= uv_cnt_reg + 16'h0001;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      to_cnt_reg <= 16'h0000;
      to_hit_reg <= 1'b0;
    end
    else if (!frame_low)
    begin
      to_cnt_reg <= 16'h0000;
      to_hit_reg <= 1'b0;
    end
    else if (to_cnt_reg >= TO_CYC[15:0])
      to_hit_reg <= 1'b1;
    else
      to_cnt_reg <= to_cnt_reg + 16'h0001;
  end

  // Latched faults; a set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gf_lat_reg <= 1'b0;
      acc_lat_reg <= 1'b0;
      uv_lat_reg <= 1'b0;
      lockout_reg <= 1'b0;
      last_selftest_lockout_reg <= 1'b0;
    end
    else if (hard_reset)
    begin
      gf_lat_reg <= 1'b0;
      acc_lat_reg <= 1'b0;
      uv_lat_reg <= 1'b0;
      lockout_reg <= 1'b0;
      last_selftest_lockout_reg <= 1'b0;
    end
    else
    begin
      if (cmd_selftest_lockout && last_selftest_lockout_reg)
        lockout_reg <= 1'b1;
      if (cmd_selftest_lockout)
        last_selftest_lockout_reg <= 1'b1;
      else if (cmd_other)
        last_selftest_lockout_reg <= 1'b0;
      // Without lockout flags follow the live conditions
      if (gf_hit_reg)
        gf_lat_reg <= 1'b1;
      else if (!lockout_reg || cmd_clear)
        gf_lat_reg <= 1'b0;
      if (fault_now_acc)
        acc_lat_reg <= 1'b1;
      else if (!lockout_reg || cmd_clear)
        acc_lat_reg <= 1'b0;
      if (hold_cap_supply_low)
        uv_lat_reg <= 1'b1;
      else if (!lockout_reg || cmd_clear)
        uv_lat_reg <= 1'b0;
    end
  end

  // Control register and bus switch
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg <= `FSM_CTRL_RESET;
      bus_switch_closed <= 1'b0;
    end
    else
    begin
      if (ph_valid_reg && ph_write_reg && ph_addr_reg == `FSM_REG_CTRL)
        ctrl_reg <= {21'h000000, hwdata[10:0]};
      if (hard_reset)
        bus_switch_closed <= 1'b0;
      else if (cmd_init && hwdata[`FSM_INIT_D6_BIT])
        bus_switch_closed <= 1'b1;
    end
  end

  // Outputs all from flops
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ground_fault_flag <= 1'b0;
      accel_fault_flag <= 1'b0;
      undervoltage_flag <= 1'b0;
      accel_force_zero <= 1'b0;
      device_in_reset <= 1'b1;
      spi_din <= 1'b0;
      filter_monitor_as_input <= 1'b0;
    end
    else
    begin
      ground_fault_flag <= gf_lat_reg;
      accel_fault_flag <= acc_lat_reg;
      undervoltage_flag <= uv_lat_reg;
      accel_force_zero <= gf_lat_reg | acc_lat_reg | uv_lat_reg;
      device_in_reset <= hard_reset;
      spi_din <= test_mode & sense_pin;
      filter_monitor_as_input <= test_mode & ctrl_reg[`FSM_CTRL_FILIN_BIT];
    end
  end

  // Read mux; commands read as zero
  always @*
  begin
    rd_next = 32'h00000000;
    case (haddr[11:0])
      `FSM_REG_CTRL: rd_next = ctrl_reg;
      `FSM_REG_STAT: rd_next = {25'h0000000, accel_force_zero, bus_switch_closed,
        lockout_reg, hard_reset, uv_lat_reg, gf_lat_reg, acc_lat_reg};
      `FSM_REG_SN: rd_next = hard_reset ? 32'h00000000 : SERIAL;
      `FSM_REG_TYPE: rd_next = hard_reset ? 32'h00000000 : {27'h0000000, TYPE_BITS};
      `FSM_REG_GLCNT: rd_next = {18'h00000, gl_cnt_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // AHB-Lite slave, zero wait states; ungrounded regs silently ignored
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_valid_reg <= 1'b0;
      ph_write_reg <= 1'b0;
      ph_addr_reg <= 12'h000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ph_valid_reg <= ph_start;
      ph_write_reg <= hwrite;
      ph_addr_reg <= haddr[11:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (ph_start && !hwrite)
        hrdata <= rd_next;
    end
  end

endmodule

// File: src/fsm_sync2.v
/*
  Two-flop synchroniser for a level that comes from outside the clock domain.
  Assumes the input changes slowly compared with the clock.
*/
module fsm_sync2
#(
  parameter W = 1
)
(
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] meta_reg;

  // Only the second flop reads the first
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule
